// ---- src/ced_consts.vh ----
`ifndef CED_CONSTS_VH
`define CED_CONSTS_VH

// ----------------------------------------------------------------
// geometry and widths
// ----------------------------------------------------------------
`define CED_LINE_LEN     640
`define CED_FRAME_LINES  480
`define CED_PIX_W        8
`define CED_GRAD_W       11
`define CED_MAG_W        11
`define CED_POS_W        16
`define CED_ANGLE_STAGES 5

// ----------------------------------------------------------------
// pixel values and 8-bit magnitude limit
// ----------------------------------------------------------------
`define CED_PIX_MAX      8'hFF
`define CED_MAG_MAX8     11'h0FF

// ----------------------------------------------------------------
// direction codes and slope limits (tan 22.5 and tan 67.5, x/256)
// ----------------------------------------------------------------
`define CED_DIR_0        2'h0
`define CED_DIR_45       2'h1
`define CED_DIR_90       2'h2
`define CED_DIR_135      2'h3
`define CED_TAN_LO       20'h0006A
`define CED_TAN_HI       20'h0026A

`endif

// ---- src/ced_edge_pipeline.v ----
`timescale 1ns/1ns
`include "ced_consts.vh"

// ----------------------------------------------------------------
// delay line advancing on enable
// ----------------------------------------------------------------
module ced_delay #(
    parameter W   = 10,
    parameter LEN = `CED_LINE_LEN
) (
    input  wire         clk,
    input  wire         reset_n,
    input  wire         en,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    localparam AW = (LEN > 1) ? $clog2(LEN) : 1;
    reg [W-1:0]  mem_q [0:LEN-1];
    reg [AW-1:0] ptr_q;
    integer      i;

    assign dout = mem_q[ptr_q];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q <= {AW{1'b0}};
            for (i = 0; i < LEN; i = i + 1) begin
                mem_q[i] <= {W{1'b0}};
            end
        end else if (en) begin
            mem_q[ptr_q] <= din;
            ptr_q <= (ptr_q == LEN - 1) ? {AW{1'b0}} : ptr_q + 1'b1;
        end
    end
endmodule // ced_delay

// ----------------------------------------------------------------
// 3x3 window; din = {valid, sof, pixel}; centre lags 1 line + 1 pixel
// ----------------------------------------------------------------
module ced_window3 #(
    parameter P           = 8,
    parameter LINE_LEN    = `CED_LINE_LEN,
    parameter FRAME_LINES = `CED_FRAME_LINES
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             en,
    input  wire [P+1:0]     din,
    output wire [9*P-1:0]   win,
    output wire [1:0]       centreMeta
);
    localparam PW = `CED_POS_W;
    // position constants held at counter width so no assignment truncates
    localparam [PW-1:0] LAST_COL = LINE_LEN - 1;
    localparam [PW-1:0] ROWS     = FRAME_LINES;
    localparam [PW-1:0] BACK_ONE = {{(PW-1){1'b0}}, 1'b1};
    localparam [PW-1:0] BACK_TWO = {{(PW-2){1'b0}}, 2'h2};
    wire [P+1:0]  row1;
    wire [P+1:0]  row2;
    reg  [P+1:0]  tap_q [0:5];
    reg  [PW-1:0] col_q;
    reg  [PW-1:0] rowPos_q;
    wire [PW-1:0] inCol = din[P] ? {PW{1'b0}} : col_q;
    wire [PW-1:0] inRow = din[P] ? {PW{1'b0}} : rowPos_q;
    wire [PW-1:0] back = (inCol == {PW{1'b0}}) ? BACK_TWO : BACK_ONE;
    wire [PW-1:0] cCol = (inCol == {PW{1'b0}}) ? LAST_COL : inCol - 1'b1;
    wire [PW-1:0] cRow = (inRow < back) ? inRow + ROWS - back : inRow - back;
    wire          mLeft  = (cCol == 0);
    wire          mRight = (cCol == LINE_LEN - 1);
    wire          mTop   = (cRow == 0);
    wire          mBot   = (cRow == FRAME_LINES - 1);
    integer       i;

    ced_delay #(.W(P+2), .LEN(LINE_LEN)) u_line1 (
        .clk(clk), .reset_n(reset_n), .en(en), .din(din), .dout(row1));
    ced_delay #(.W(P+2), .LEN(LINE_LEN)) u_line2 (
        .clk(clk), .reset_n(reset_n), .en(en), .din(row1), .dout(row2));

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            col_q    <= {PW{1'b0}};
            rowPos_q <= {PW{1'b0}};
            for (i = 0; i < 6; i = i + 1) begin
                tap_q[i] <= {(P+2){1'b0}};
            end
        end else if (en) begin
            tap_q[0] <= din;
            tap_q[1] <= tap_q[0];
            tap_q[2] <= row1;
            tap_q[3] <= tap_q[2];
            tap_q[4] <= row2;
            tap_q[5] <= tap_q[4];
            col_q <= (inCol == LINE_LEN - 1) ? {PW{1'b0}} : inCol + 1'b1;
            if (inCol == LINE_LEN - 1) begin
                rowPos_q <= (inRow == FRAME_LINES - 1) ? {PW{1'b0}} : inRow + 1'b1;
            end else begin
                rowPos_q <= inRow;
            end
        end
    end

    // index = rr*3 + kk, rr 0 top .. 2 bottom, kk 0 left .. 2 right
    genvar g;
    generate
        for (g = 0; g < 9; g = g + 1) begin : g_win
            wire [P+1:0] newest = (g / 3 == 0) ? row2 : (g / 3 == 1) ? row1 : din;
            wire [P+1:0] src    = (g % 3 == 2) ? newest :
                                  (g % 3 == 1) ? tap_q[2*(2-g/3)] : tap_q[2*(2-g/3)+1];
            wire         kill   = (g % 3 == 0 && mLeft) || (g % 3 == 2 && mRight) ||
                                  (g / 3 == 0 && mTop)  || (g / 3 == 2 && mBot);
            assign win[g*P +: P] = kill ? {P{1'b0}} : src[P-1:0];
        end
    endgenerate

    assign centreMeta = tap_q[2][P+1:P];
endmodule // ced_window3

// ----------------------------------------------------------------
// top: grey, blur, sobel, angle, thinning, double threshold
// ----------------------------------------------------------------
module ced_edge_pipeline #(
    parameter LINE_LEN    = `CED_LINE_LEN,
    parameter FRAME_LINES = `CED_FRAME_LINES
) (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       vidDe,
    input  wire       vidSof,
    input  wire [7:0] vidRed,
    input  wire [7:0] vidGreen,
    input  wire [7:0] vidBlue,
    input  wire [7:0] thrLow,
    input  wire [7:0] thrHigh,
    output reg        sobelDe,
    output reg  [7:0] sobelPixel,
    output reg        edgeDe,
    output reg  [7:0] edgePixel,
    input  wire       frameDone,
    input  wire       memValid,
    input  wire [7:0] memPixel,
    output reg        dispDe,
    output reg  [7:0] dispPixel
);
    localparam GW = `CED_GRAD_W;
    localparam MW = `CED_MAG_W;
    localparam TW = MW + 2;

    // ------------------------------------------------------------
    // input registers and grey
    // ------------------------------------------------------------
    reg        de_q;
    reg        sof_q;
    reg  [7:0] red_q;
    reg  [7:0] green_q;
    reg  [7:0] blue_q;
    reg  [9:0] grey_q;
    wire       en = de_q;
    // 77R + 150G + 29B, all as shifts, no multipliers
    wire [15:0] lumR = {8'h00, red_q} + {2'h0, red_q, 6'h00} + {5'h00, red_q, 3'h0} + {6'h00, red_q, 2'h0};
    wire [15:0] lumG = {1'h0, green_q, 7'h00} + {4'h0, green_q, 4'h0} + {6'h00, green_q, 2'h0}
                     + {7'h00, green_q, 1'h0};
    wire [15:0] lumB = {4'h0, blue_q, 4'h0} + {5'h00, blue_q, 3'h0} + {6'h00, blue_q, 2'h0} + {8'h00, blue_q};
    wire [15:0] lum  = lumR + lumG + lumB;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            de_q    <= 1'b0;
            sof_q   <= 1'b0;
            red_q   <= 8'h00;
            green_q <= 8'h00;
            blue_q  <= 8'h00;
            grey_q  <= 10'h000;
        end else begin
            de_q    <= vidDe;
            sof_q   <= vidSof & vidDe;
            red_q   <= vidRed;
            green_q <= vidGreen;
            blue_q  <= vidBlue;
            if (en) begin
                grey_q <= {1'b1, sof_q, lum[15:8]};
            end
        end
    end

    // ------------------------------------------------------------
    // gaussian blur: window, weighted sum, trailing line delay
    // ------------------------------------------------------------
    wire [71:0] bw;
    wire [1:0]  bMeta;
    reg  [9:0]  blur_q;
    wire [9:0]  blurD;
    wire [11:0] bSum = {4'h0, bw[7:0]} + {3'h0, bw[15:8], 1'b0} + {4'h0, bw[23:16]}
                     + {3'h0, bw[31:24], 1'b0} + {2'h0, bw[39:32], 2'h0} + {3'h0, bw[47:40], 1'b0}
                     + {4'h0, bw[55:48]} + {3'h0, bw[63:56], 1'b0} + {4'h0, bw[71:64]};

    ced_window3 #(.P(8), .LINE_LEN(LINE_LEN), .FRAME_LINES(FRAME_LINES)) u_blurWin (
        .clk(clk), .reset_n(reset_n), .en(en), .din(grey_q), .win(bw), .centreMeta(bMeta));

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blur_q <= 10'h000;
        end else if (en) begin
            blur_q <= {bMeta, bSum[11:4]};
        end
    end

    // extra line keeps each window stage at two lines plus two pixels
    ced_delay #(.W(10), .LEN(LINE_LEN)) u_blurLine (
        .clk(clk), .reset_n(reset_n), .en(en), .din(blur_q), .dout(blurD));

    // ------------------------------------------------------------
    // sobel gradients
    // ------------------------------------------------------------
    wire [71:0] sw;
    wire [1:0]  sMeta;
    reg  [2*GW+1:0] grad_q;
    wire [2*GW+1:0] gradD;
    wire [11:0] sRight = {4'h0, sw[23:16]} + {3'h0, sw[47:40], 1'b0} + {4'h0, sw[71:64]};
    wire [11:0] sLeft  = {4'h0, sw[7:0]} + {3'h0, sw[31:24], 1'b0} + {4'h0, sw[55:48]};
    wire [11:0] sDown  = {4'h0, sw[55:48]} + {3'h0, sw[63:56], 1'b0} + {4'h0, sw[71:64]};
    wire [11:0] sUp    = {4'h0, sw[7:0]} + {3'h0, sw[15:8], 1'b0} + {4'h0, sw[23:16]};
    wire [11:0] gxFull = sRight - sLeft;
    wire [11:0] gyFull = sDown - sUp;

    ced_window3 #(.P(8), .LINE_LEN(LINE_LEN), .FRAME_LINES(FRAME_LINES)) u_sobelWin (
        .clk(clk), .reset_n(reset_n), .en(en), .din(blurD), .win(sw), .centreMeta(sMeta));

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            grad_q <= {(2*GW+2){1'b0}};
        end else if (en) begin
            grad_q <= {sMeta, gxFull[GW-1:0], gyFull[GW-1:0]};
        end
    end

    ced_delay #(.W(2*GW+2), .LEN(LINE_LEN)) u_sobelLine (
        .clk(clk), .reset_n(reset_n), .en(en), .din(grad_q), .dout(gradD));

    // ------------------------------------------------------------
    // magnitude, angle quantisation, five-stage angle pipe
    // ------------------------------------------------------------
    wire [GW-1:0] gx = gradD[2*GW-1:GW];
    wire [GW-1:0] gy = gradD[GW-1:0];
    wire [9:0]    ax = gx[GW-1] ? 10'h000 - gx[9:0] : gx[9:0];
    wire [9:0]    ay = gy[GW-1] ? 10'h000 - gy[9:0] : gy[9:0];
    wire [MW-1:0] mag = {1'b0, ax} + {1'b0, ay};
    wire [19:0]   ayS = {2'h0, ay, 8'h00};
    wire [19:0]   axLo = {10'h000, ax} * `CED_TAN_LO;
    wire [19:0]   axHi = {10'h000, ax} * `CED_TAN_HI;
    // y grows downward, so equal signs mean a down-right gradient
    wire [1:0]    dir = (ayS <= axLo) ? `CED_DIR_0 :
                        (ayS >= axHi) ? `CED_DIR_90 :
                        (gx[GW-1] == gy[GW-1]) ? `CED_DIR_45 : `CED_DIR_135;
    reg  [TW+1:0] ang_q [0:`CED_ANGLE_STAGES-1];
    integer       k;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (k = 0; k < `CED_ANGLE_STAGES; k = k + 1) begin
                ang_q[k] <= {(TW+2){1'b0}};
            end
            sobelDe    <= 1'b0;
            sobelPixel <= 8'h00;
        end else begin
            sobelDe <= en & gradD[2*GW+1];
            if (en) begin
                ang_q[0] <= {gradD[2*GW+1:2*GW], dir, mag};
                for (k = 1; k < `CED_ANGLE_STAGES; k = k + 1) begin
                    ang_q[k] <= ang_q[k-1];
                end
                // saturating keeps the display bright where scaling would dim it
                sobelPixel <= (mag > `CED_MAG_MAX8) ? `CED_PIX_MAX : mag[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // edge thinning stage
    // ------------------------------------------------------------
    wire [9*TW-1:0] tw;
    wire [1:0]      tMeta;
    reg  [MW+1:0]   thin_q;
    wire [MW+1:0]   thinD;
    wire [1:0]      cDir = tw[4*TW+MW +: 2];
    wire [MW-1:0]   cMag = tw[4*TW +: MW];
    reg  [MW-1:0]   nA;
    reg  [MW-1:0]   nB;

    ced_window3 #(.P(TW), .LINE_LEN(LINE_LEN), .FRAME_LINES(FRAME_LINES)) u_thinWin (
        .clk(clk), .reset_n(reset_n), .en(en), .din(ang_q[`CED_ANGLE_STAGES-1]),
        .win(tw), .centreMeta(tMeta));

    always @* begin
        case (cDir)
            `CED_DIR_0: begin
                nA = tw[3*TW +: MW];
                nB = tw[5*TW +: MW];
            end
            `CED_DIR_90: begin
                nA = tw[1*TW +: MW];
                nB = tw[7*TW +: MW];
            end
            `CED_DIR_45: begin
                nA = tw[0*TW +: MW];
                nB = tw[8*TW +: MW];
            end
            default: begin
                nA = tw[2*TW +: MW];
                nB = tw[6*TW +: MW];
            end
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            thin_q <= {(MW+2){1'b0}};
        end else if (en) begin
            thin_q <= {tMeta, (cMag >= nA && cMag >= nB) ? cMag : {MW{1'b0}}};
        end
    end

    ced_delay #(.W(MW+2), .LEN(LINE_LEN)) u_thinLine (
        .clk(clk), .reset_n(reset_n), .en(en), .din(thin_q), .dout(thinD));

    // ------------------------------------------------------------
    // double threshold, stream-to-memory output, playback
    // ------------------------------------------------------------
    wire [MW-1:0] tMag = thinD[MW-1:0];
    reg           play_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            edgeDe    <= 1'b0;
            edgePixel <= 8'h00;
            play_q    <= 1'b0;
            dispDe    <= 1'b0;
            dispPixel <= 8'h00;
        end else begin
            edgeDe <= en & thinD[MW+1];
            if (en) begin
                if (tMag < {3'h0, thrLow}) begin
                    edgePixel <= 8'h00;
                end else if (tMag > {3'h0, thrHigh}) begin
                    edgePixel <= `CED_PIX_MAX;
                end else begin
                    edgePixel <= thrHigh;
                end
            end
            if (frameDone) begin
                play_q <= 1'b1;
            end
            dispDe <= play_q & memValid;
            if (play_q & memValid) begin
                dispPixel <= memPixel;
            end
        end
    end
endmodule // ced_edge_pipeline

// ---- tb/ced_edge_pipeline_monitor.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// stream checker
// ----------------------------------------------------------------
module ced_edge_pipeline_monitor #(
    parameter LINE_LEN    = 640,
    parameter FRAME_LINES = 480
) (
    input wire       clk,
    input wire       reset_n,
    input wire       vidDe,
    input wire       vidSof,
    input wire [7:0] vidRed,
    input wire [7:0] vidGreen,
    input wire [7:0] vidBlue,
    input wire [7:0] thrLow,
    input wire [7:0] thrHigh,
    input wire       sobelDe,
    input wire [7:0] sobelPixel,
    input wire       edgeDe,
    input wire [7:0] edgePixel,
    input wire       frameDone,
    input wire       memValid,
    input wire [7:0] memPixel,
    input wire       dispDe,
    input wire [7:0] dispPixel
);
    // in-flight counts: a lost or invented pixel breaks the bounds
    reg        playOn_q;
    reg [15:0] edgeCnt_q;
    reg [15:0] sobelCnt_q;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            playOn_q   <= 1'b0;
            edgeCnt_q  <= 16'h0000;
            sobelCnt_q <= 16'h0000;
        end else begin
            playOn_q   <= playOn_q | frameDone;
            edgeCnt_q  <= edgeCnt_q + {15'h0000, vidDe} - {15'h0000, edgeDe};
            sobelCnt_q <= sobelCnt_q + {15'h0000, vidDe} - {15'h0000, sobelDe};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_edge_values: assert property (edgeDe |->
        (edgePixel == 8'h00 || edgePixel == thrHigh || edgePixel == 8'hFF))
        else $error("edge pixel outside class values");
    a_edge_paced: assert property (edgeDe |-> ($past(vidDe) || $past(vidDe, 2) || $past(vidDe, 3)))
        else $error("edge output without input pixel");
    a_sobel_paced: assert property (sobelDe |-> ($past(vidDe) || $past(vidDe, 2) || $past(vidDe, 3)))
        else $error("sobel output without input pixel");
    a_edge_count: assert property (edgeDe |-> edgeCnt_q != 16'h0000)
        else $error("more edge outputs than inputs");
    a_edge_bound: assert property (edgeCnt_q <= 6 * LINE_LEN + 16)
        else $error("edge pipeline holds too many pixels");
    a_sobel_bound: assert property (sobelCnt_q <= 4 * LINE_LEN + 10)
        else $error("sobel pipeline holds too many pixels");
    a_disp_copy: assert property (playOn_q && memValid |=> dispDe && dispPixel == $past(memPixel))
        else $error("display pixel not copied from memory");
    a_disp_idle: assert property (!memValid |=> !dispDe)
        else $error("display enable without memory pixel");
    a_disp_gated: assert property (!playOn_q && !frameDone |=> !dispDe)
        else $error("display before frame finished");
    c_strong: cover property (edgeDe && edgePixel == 8'hFF);
    c_weak: cover property (edgeDe && edgePixel == thrHigh && thrHigh != 8'hFF && thrHigh != 8'h00);
    c_disp: cover property (dispDe);
endmodule // ced_edge_pipeline_monitor

// ---- tb/ced_edge_pipeline_tb.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// harness and reference
// ----------------------------------------------------------------
module ced_edge_pipeline_tb;
    localparam int L = 8;
    localparam int F = 6;
    localparam int N = L * F;
    reg        clk      = 1'b0;
    reg        reset_n  = 1'b0;
    reg        vidDe    = 1'b0;
    reg        vidSof   = 1'b0;
    reg  [7:0] vidRed   = 8'h00;
    reg  [7:0] vidGreen = 8'h00;
    reg  [7:0] vidBlue  = 8'h00;
    reg  [7:0] thrLow   = 8'h00;
    reg  [7:0] thrHigh  = 8'h00;
    reg        start    = 1'b0;
    wire       sobelDe, edgeDe, dispDe, frameDone, memValid;
    wire [7:0] sobelPixel, edgePixel, dispPixel, memPixel;
    integer    errors = 0;
    integer    checks = 0;
    integer    cyc = 0, tIn = -1, tOut = -1, tLast = -1;
    reg  [7:0] edgeQ[$], sobelQ[$], dispQ[$];
    ced_edge_pipeline #(.LINE_LEN(L), .FRAME_LINES(F)) dut (
        .clk(clk), .reset_n(reset_n), .vidDe(vidDe), .vidSof(vidSof), .vidRed(vidRed),
        .vidGreen(vidGreen), .vidBlue(vidBlue), .thrLow(thrLow), .thrHigh(thrHigh),
        .sobelDe(sobelDe), .sobelPixel(sobelPixel), .edgeDe(edgeDe), .edgePixel(edgePixel),
        .frameDone(frameDone), .memValid(memValid), .memPixel(memPixel), .dispDe(dispDe),
        .dispPixel(dispPixel));
    ced_mem_model #(.N(N)) mem (
        .clk(clk), .reset_n(reset_n), .edgeDe(edgeDe), .edgePixel(edgePixel), .start(start),
        .frameDone(frameDone), .memValid(memValid), .memPixel(memPixel));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (vidDe === 1'b1 && tIn < 0) tIn = cyc;
        if (edgeDe === 1'b1) begin
            edgeQ.push_back(edgePixel);
            if (tOut < 0) tOut = cyc;
            tLast = cyc;
        end
        if (sobelDe === 1'b1) sobelQ.push_back(sobelPixel);
        if (dispDe === 1'b1) dispQ.push_back(dispPixel);
    end
    function automatic int px(int r, int c);
        return c * c * 4 + r * 9;
    endfunction
    // outside the image every stage reads zero
    function automatic int gr(int r, int c);
        if (r < 0 || r >= F || c < 0 || c >= L) return 0;
        return (77 * px(r, c) + 150 * (px(r, c) >> 1) + 29 * (255 - px(r, c))) >> 8;
    endfunction
    function automatic int bl(int r, int c);
        int s = 0;
        if (r < 0 || r >= F || c < 0 || c >= L) return 0;
        for (int i = -1; i < 2; i++) for (int j = -1; j < 2; j++) s += (2 - i * i) * (2 - j * j) * gr(r + i, c + j);
        return s >> 4;
    endfunction
    function automatic int mg(int r, int c, output int d);
        int gx = 0, gy = 0, ax, ay;
        d = 0;
        if (r < 0 || r >= F || c < 0 || c >= L) return 0;
        for (int i = -1; i < 2; i++) begin
            gx += (2 - i * i) * (bl(r + i, c + 1) - bl(r + i, c - 1));
            gy += (2 - i * i) * (bl(r + 1, c + i) - bl(r - 1, c + i));
        end
        ax = gx < 0 ? -gx : gx;
        ay = gy < 0 ? -gy : gy;
        if (ay * 256 <= ax * 106) d = 0;
        else if (ay * 256 >= ax * 618) d = 2;
        else d = ((gx < 0) == (gy < 0)) ? 1 : 3;
        return ax + ay;
    endfunction
    function automatic int sx(int i);
        int d, m;
        m = mg(i / L, i % L, d);
        return m > 255 ? 255 : m;
    endfunction
    function automatic int ex(int i);
        int r = i / L, c = i % L, d, x, m, dr, dc;
        m = mg(r, c, d);
        dr = (d == 0) ? 0 : -1;
        dc = (d == 2) ? 0 : ((d == 3) ? 1 : -1);
        if (m < mg(r + dr, c + dc, x) || m < mg(r - dr, c - dc, x)) m = 0;
        if (m < thrLow) return 0;
        return m > thrHigh ? 255 : thrHigh;
    endfunction
    task automatic cmpPix(input [7:0] got, input [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s pixel got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic cmpNum(input int got, input int exp, input string what);
        checks++;
        if (got != exp) begin
            errors++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic conclude;
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rst(input [7:0] lo, input [7:0] hi);
        reset_n <= 1'b0;
        thrLow  <= lo;
        thrHigh <= hi;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        edgeQ.delete();
        sobelQ.delete();
        dispQ.delete();
        tIn  = -1;
        tOut = -1;
    endtask
    // idle cycles carry changing colour so a leak past the enable shows
    task automatic feed(input int frames, input int gap);
        for (int k = 0; k < frames * N; k++) begin
            @(posedge clk);
            vidDe    <= 1'b1;
            vidSof   <= (k % N == 0);
            vidRed   <= 8'(px(k % N / L, k % L));
            vidGreen <= 8'(px(k % N / L, k % L) >> 1);
            vidBlue  <= 8'(255 - px(k % N / L, k % L));
            repeat (gap) begin
                @(posedge clk);
                vidDe  <= 1'b0;
                vidRed <= ~vidRed;
            end
        end
        @(posedge clk);
        vidDe  <= 1'b0;
        vidSof <= 1'b0;
    endtask
    task automatic chk(input int nf);
        for (int k = 0; k < nf * N; k++) begin
            cmpPix(k < edgeQ.size() ? edgeQ[k] : 8'hXX, 8'(ex(k % N)), "edge");
            cmpPix(k < sobelQ.size() ? sobelQ[k] : 8'hXX, 8'(sx(k % N)), "sobel");
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic stream_classes;
        int lo[3] = '{40, 60, 0};
        int hi[3] = '{120, 60, 255};
        for (int t = 0; t < 3; t++) begin
            rst(8'(lo[t]), 8'(hi[t]));
            feed(4, 0);
            chk(2);
            cmpNum(tOut - tIn, 6 * L + 14, "latency");
            cmpNum(tLast - tOut + 1, edgeQ.size(), "throughput");
        end
    endtask
    task automatic stream_paused;
        rst(8'h32, 8'h5A);
        feed(4, 2);
        chk(2);
    endtask
    task automatic playback;
        int n = 0;
        rst(8'h28, 8'h78);
        feed(3, 1);
        cmpNum(dispQ.size(), 0, "early display");
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        while (dispQ.size() < N && n < 4 * N) begin
            @(posedge clk);
            n++;
        end
        if (dispQ.size() < N) begin
            cmpNum(dispQ.size(), N, "display wait");
            conclude();
        end else begin
            for (int k = 0; k < N; k++) cmpPix(dispQ[k], 8'(ex(k)), "display");
        end
    endtask
    initial begin
        stream_classes();
        stream_paused();
        playback();
        conclude();
    end
endmodule // ced_edge_pipeline_tb
bind ced_edge_pipeline ced_edge_pipeline_monitor #(.LINE_LEN(LINE_LEN), .FRAME_LINES(FRAME_LINES)) mon (
    .clk(clk), .reset_n(reset_n), .vidDe(vidDe), .vidSof(vidSof), .vidRed(vidRed), .vidGreen(vidGreen),
    .vidBlue(vidBlue), .thrLow(thrLow), .thrHigh(thrHigh), .sobelDe(sobelDe), .sobelPixel(sobelPixel),
    .edgeDe(edgeDe), .edgePixel(edgePixel), .frameDone(frameDone), .memValid(memValid),
    .memPixel(memPixel), .dispDe(dispDe), .dispPixel(dispPixel));

// ---- tb/ced_mem_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// far-side frame memory: captures one frame, replays it slowly
// ----------------------------------------------------------------
module ced_mem_model #(
    parameter N = 48
) (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       edgeDe,
    input  wire [7:0] edgePixel,
    input  wire       start,
    output reg        frameDone,
    output reg        memValid,
    output reg  [7:0] memPixel
);
    reg [7:0] frame [0:N-1];
    integer   wrIdx_q;
    integer   rdIdx_q;
    reg       tog_q;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrIdx_q   <= 0;
            rdIdx_q   <= N;
            tog_q     <= 1'b0;
            frameDone <= 1'b0;
            memValid  <= 1'b0;
            memPixel  <= 8'h00;
        end else begin
            frameDone <= start;
            tog_q     <= ~tog_q;
            memValid  <= 1'b0;
            // idle data keeps moving so a stale copy cannot pass
            memPixel  <= ~memPixel;
            if (edgeDe && wrIdx_q < N) begin
                frame[wrIdx_q] <= edgePixel;
                wrIdx_q        <= wrIdx_q + 1;
            end
            if (start) rdIdx_q <= 0;
            else if (rdIdx_q < N && tog_q) begin
                memValid <= 1'b1;
                memPixel <= frame[rdIdx_q];
                rdIdx_q  <= rdIdx_q + 1;
            end
        end
    end
endmodule // ced_mem_model
